// ### core/gauge_flash_access.sv
/*
 * Block window access to configuration memory with three-level security over the command port.
 * Assumes the command front end delivers byte requests on clk, one per cycle at most.
 */
`timescale 1ns/100ps

module gauge_flash_access (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command port
    input wire gauge_flash_pkg::cmd_req_t cmd,
    input wire logic [7:0] std_rd_data,
    // Read answer
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    // Status
    output logic sealed_status_q,
    output logic full_access_status_bit_q,
    output logic commit_done_q,
    output logic commit_fail_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.
    gauge_flash_pkg::sec_state_t sec_q;
    gauge_flash_pkg::sec_state_t sec_d;
    gauge_flash_pkg::key_step_t key_q;
    gauge_flash_pkg::key_step_t key_d;
    logic [7:0] class_q;
    logic [7:0] block_q;
    logic [7:0] mode_q;
    logic [7:0] ctrl_lo_q;
    logic [255:0] win_q;
    logic reload_q;
    logic [5:0] burst_q;
    logic over_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.
    wire logic sealed = (sec_q == gauge_flash_pkg::SEC_SEALED);
    wire logic mfr_sel = (block_q == gauge_flash_pkg::MFR_A_INDEX) &&
        (mode_q == gauge_flash_pkg::MODE_SEALED_STYLE || sealed);
    wire logic sec_class = (class_q == gauge_flash_pkg::SECURITY_CLASS);
    wire logic [5:0] gen_slot = {1'b0, class_q[3:0], block_q[0]};
    wire logic [5:0] slot = mfr_sel ? gauge_flash_pkg::SLOT_MFR_A :
        (sec_class ? gauge_flash_pkg::SLOT_SECURITY : gen_slot);
    wire logic win_access = !sealed || mfr_sel;
    wire logic in_win = (cmd.addr >= gauge_flash_pkg::CMD_WIN_BASE) &&
        (cmd.addr <= gauge_flash_pkg::CMD_WIN_LAST);
    wire logic [4:0] win_idx = cmd.addr[4:0];

    wire logic wr_class = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_CLASS && !sealed;
    // While sealed, block index select only accepts the manufacturer block A index.
    wire logic wr_block = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_BLOCK &&
        (!sealed || cmd.wdata == gauge_flash_pkg::MFR_A_INDEX);
    wire logic wr_mode = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_MODE && !sealed;
    wire logic win_hit = cmd.wr && in_win;
    // A start in the same cycle opens a fresh burst, so a stale count must not judge it.
    wire logic [5:0] burst_cnt = cmd.start ? gauge_flash_pkg::BURST_RESET : burst_q;
    wire logic over_now = over_q && !cmd.start;
    wire logic burst_over = win_hit && burst_cnt == gauge_flash_pkg::BURST_MAX;
    wire logic wr_win = win_hit && win_access && !over_now && !burst_over;
    wire logic wr_sum = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_SUM && win_access;
    wire logic ctrl_stb = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_CTRL_HI;
    wire logic [15:0] ctrl_word = {cmd.wdata, ctrl_lo_q};
    wire logic reselect = wr_class || wr_block || wr_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Checksum of the window as it stands.
    function automatic logic [7:0] byte_sum(input logic [255:0] blk);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < gauge_flash_pkg::BLOCK_BYTES; i++) begin
            acc = acc + blk[i*8 +: 8];
        end
        return acc;
    endfunction

    wire logic [7:0] expect_sum = gauge_flash_pkg::SUM_FULL - byte_sum(win_q);
    // Key blocks may only be committed at full access; overflowed bursts never commit.
    wire logic key_guard = (slot == gauge_flash_pkg::SLOT_SECURITY) &&
        (sec_q != gauge_flash_pkg::SEC_FULL);
    wire logic commit_ok = wr_sum && cmd.wdata == expect_sum && !key_guard &&
        !over_now && !burst_over;

    ////////////////////////////////////////////////////////////////////////////////
    // Store.
    logic [255:0] store_rd;
    logic [255:0] sec_blk;

    nv_block_store store (
        .clk(clk),
        .wr_en(commit_ok),
        .wr_slot(slot),
        .wr_data(win_q),
        .rd_slot(slot),
        .rd_data(store_rd),
        .sec_data(sec_blk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Key sequences. Stored bytes read back low first, so the word arrives unswapped.
    wire logic [15:0] ukey0 = {sec_blk[(gauge_flash_pkg::UNSEAL_KEY_OFS+1)*8 +: 8],
        sec_blk[gauge_flash_pkg::UNSEAL_KEY_OFS*8 +: 8]};
    wire logic [15:0] ukey1 = {sec_blk[(gauge_flash_pkg::UNSEAL_KEY_OFS+3)*8 +: 8],
        sec_blk[(gauge_flash_pkg::UNSEAL_KEY_OFS+2)*8 +: 8]};
    wire logic [15:0] fkey0 = {sec_blk[(gauge_flash_pkg::FULL_KEY_OFS+1)*8 +: 8],
        sec_blk[gauge_flash_pkg::FULL_KEY_OFS*8 +: 8]};
    wire logic [15:0] fkey1 = {sec_blk[(gauge_flash_pkg::FULL_KEY_OFS+3)*8 +: 8],
        sec_blk[(gauge_flash_pkg::FULL_KEY_OFS+2)*8 +: 8]};

    always_comb begin
        sec_d = sec_q;
        key_d = key_q;
        if (ctrl_stb) begin
            // Any control high-byte write ends a pending half; only a matching first key starts one.
            key_d = gauge_flash_pkg::KEY_NONE;
            case (sec_q)
                gauge_flash_pkg::SEC_SEALED: begin
                    if (key_q == gauge_flash_pkg::KEY_UNSEAL_HALF && ctrl_word == ukey1) begin
                        sec_d = gauge_flash_pkg::SEC_UNSEALED;
                    end else if (ctrl_word == ukey0) begin
                        key_d = gauge_flash_pkg::KEY_UNSEAL_HALF;
                    end
                end
                gauge_flash_pkg::SEC_UNSEALED: begin
                    if (key_q == gauge_flash_pkg::KEY_FULL_HALF && ctrl_word == fkey1) begin
                        sec_d = gauge_flash_pkg::SEC_FULL;
                    end else if (ctrl_word == gauge_flash_pkg::SEAL_SUBCMD) begin
                        sec_d = gauge_flash_pkg::SEC_SEALED;
                    end else if (ctrl_word == fkey0) begin
                        key_d = gauge_flash_pkg::KEY_FULL_HALF;
                    end
                end
                gauge_flash_pkg::SEC_FULL: begin
                    if (ctrl_word == gauge_flash_pkg::SEAL_SUBCMD) begin
                        sec_d = gauge_flash_pkg::SEC_SEALED;
                    end
                end
                default: begin
                    sec_d = gauge_flash_pkg::SEC_SEALED;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec_q <= gauge_flash_pkg::SEC_SEALED;
            key_q <= gauge_flash_pkg::KEY_NONE;
            ctrl_lo_q <= gauge_flash_pkg::RESET_BYTE;
        end else begin
            sec_q <= sec_d;
            key_q <= key_d;
            if (cmd.wr && cmd.addr == gauge_flash_pkg::CMD_CTRL_LO) begin
                ctrl_lo_q <= cmd.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Selection registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            class_q <= gauge_flash_pkg::RESET_BYTE;
            block_q <= gauge_flash_pkg::RESET_BYTE;
            mode_q <= gauge_flash_pkg::MODE_GENERAL;
            reload_q <= 1'b1;
        end else begin
            if (wr_class) begin
                class_q <= cmd.wdata;
            end
            if (wr_block) begin
                block_q <= cmd.wdata;
            end
            if (wr_mode) begin
                mode_q <= cmd.wdata;
            end
            reload_q <= reselect || burst_over;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-burst length. A burst is bounded by cmd.start; the count is cheap insurance
    // against a host that streams past the block end and would wrap onto byte zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            burst_q <= gauge_flash_pkg::BURST_RESET;
            over_q <= 1'b0;
        end else begin
            over_q <= over_now || burst_over;
            if (win_hit && !over_now && !burst_over) begin
                burst_q <= burst_cnt + 6'h01;
            end else begin
                burst_q <= burst_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Window. Reload follows every accepted selection one cycle later.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            win_q <= '0;
        end else if (reload_q) begin
            win_q <= store_rd;
        end else if (wr_win) begin
            win_q[win_idx*8 +: 8] <= cmd.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answers and status.
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = std_rd_data;
        if (cmd.addr == gauge_flash_pkg::CMD_CLASS) begin
            rd_mux = sealed ? 8'h00 : class_q;
        end else if (cmd.addr == gauge_flash_pkg::CMD_BLOCK) begin
            rd_mux = block_q;
        end else if (cmd.addr == gauge_flash_pkg::CMD_MODE) begin
            rd_mux = sealed ? 8'h00 : mode_q;
        end else if (cmd.addr == gauge_flash_pkg::CMD_SUM) begin
            rd_mux = win_access ? expect_sum : 8'h00;
        end else if (in_win) begin
            rd_mux = win_access ? win_q[win_idx*8 +: 8] : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            sealed_status_q <= 1'b1;
            full_access_status_bit_q <= 1'b1;
            commit_done_q <= 1'b0;
            commit_fail_q <= 1'b0;
        end else begin
            rd_data_q <= cmd.rd ? rd_mux : 8'h00;
            rd_valid_q <= cmd.rd;
            sealed_status_q <= sealed;
            full_access_status_bit_q <= (sec_q != gauge_flash_pkg::SEC_FULL);
            commit_done_q <= commit_ok;
            commit_fail_q <= cmd.wr && cmd.addr == gauge_flash_pkg::CMD_SUM && !commit_ok;
        end
    end

endmodule

// ### core/gauge_flash_pkg.sv
/*
 * Constants, types and command layout for the configuration memory block access logic.
 * Assumes a command-port front end on the same clock that delivers one byte per request.
 */
// What this block does
// - Writing 0x00 to block mode select at 0x61 maps the selected general block.
// - Up to 32 bytes of the selected block appear at 0x40, readable and writable.
// - Single window bytes may be read or rewritten by offset without moving the block.
// - The window is committed to memory only after a correct checksum at 0x60.
// - Long classes use block index select, then byte 0x40 plus offset modulo 32.
// - A write burst longer than 32 bytes is discarded; stored contents stay unchanged.
// - Written values are never range checked, and committed values survive reset.
// - Standard read commands stay reachable in both sealed and unsealed states.
// - Three levels; sealed denies general memory and only reads manufacturer block A, which the code also lets sealed write and commit.
// - Security keys are writable only at full access, otherwise equal to unsealed.
// - Unseal and full access each need two back-to-back key words; any other control high-byte write voids it.
// - Sealed status bit is set while sealed and cleared by the correct unseal pair.
// - Full-access status bit clears when the correct full-access key pair arrives.
// - Each key is 4 bytes, held in non-volatile memory, updated only at full access.
// - Class select 0x3e is refused while sealed; block index select 0x3f then accepts only 0x01.
// - Mode 0x01 makes block index 0x01 map manufacturer block A into the window.
package gauge_flash_pkg;

    localparam logic [7:0] CMD_CTRL_LO = 8'h00;
    localparam logic [7:0] CMD_CTRL_HI = 8'h01;
    localparam logic [7:0] CMD_CLASS = 8'h3E;
    localparam logic [7:0] CMD_BLOCK = 8'h3F;
    localparam logic [7:0] CMD_WIN_BASE = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST = 8'h5F;
    localparam logic [7:0] CMD_SUM = 8'h60;
    localparam logic [7:0] CMD_MODE = 8'h61;

    localparam int BLOCK_BYTES = 32;
    localparam int BLOCK_BITS = 256;
    localparam logic [7:0] MODE_GENERAL = 8'h00;
    localparam logic [7:0] MODE_SEALED_STYLE = 8'h01;
    localparam logic [7:0] MFR_A_INDEX = 8'h01;
    localparam logic [7:0] SECURITY_CLASS = 8'h70;
    localparam logic [7:0] SUM_FULL = 8'hFF;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Storage slots: 32 general, then security codes, then manufacturer block A.
    localparam int SLOT_W = 6;
    localparam int SLOTS = 34;
    localparam logic [5:0] SLOT_SECURITY = 6'h20;
    localparam logic [5:0] SLOT_MFR_A = 6'h21;

    // Security code block layout, byte offsets within the block.
    localparam int UNSEAL_KEY_OFS = 0;
    localparam int FULL_KEY_OFS = 4;
    localparam logic [31:0] UNSEAL_KEYS_DEFAULT = 32'h36720414;
    localparam logic [31:0] FULL_KEYS_DEFAULT = 32'hFFFFFFFF;
    localparam logic [15:0] SEAL_SUBCMD = 16'h0020;

    localparam logic [5:0] BURST_RESET = 6'h00;
    localparam logic [5:0] BURST_MAX = 6'h20;

    typedef enum logic [1:0] {
        SEC_SEALED,
        SEC_UNSEALED,
        SEC_FULL
    } sec_state_t;

    typedef enum logic [1:0] {
        KEY_NONE,
        KEY_UNSEAL_HALF,
        KEY_FULL_HALF
    } key_step_t;

    typedef struct packed {
        logic start;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmd_req_t;

endpackage

// ### core/nv_block_store.sv
/*
 * Non-volatile block store: one 32-byte word per slot, written whole on commit.
 * Assumes the caller validates every commit; the array has no reset so contents persist.
 */
`timescale 1ns/100ps

module nv_block_store (
    // Clock
    input wire logic clk,
    // Commit port
    input wire logic wr_en,
    input wire logic [5:0] wr_slot,
    input wire logic [255:0] wr_data,
    // Read ports
    input wire logic [5:0] rd_slot,
    output logic [255:0] rd_data,
    output logic [255:0] sec_data
);

    logic [255:0] mem [0:gauge_flash_pkg::SLOTS-1];

    ////////////////////////////////////////////////////////////////////////////////
    // Power-on image; sys_rst never touches this array, so commits survive it.
    initial begin
        for (int i = 0; i < gauge_flash_pkg::SLOTS; i++) begin
            mem[i] = '0;
        end
        mem[gauge_flash_pkg::SLOT_SECURITY][31:0] = {<<8{gauge_flash_pkg::UNSEAL_KEYS_DEFAULT}};
        mem[gauge_flash_pkg::SLOT_SECURITY][63:32] = {<<8{gauge_flash_pkg::FULL_KEYS_DEFAULT}};
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_data;
        end
    end

    assign rd_data = mem[rd_slot];
    assign sec_data = mem[gauge_flash_pkg::SLOT_SECURITY];

endmodule

// ### sim/flash_access_chk_sva.sv
/* Checker for the block access ports.
   Assumes a bind onto gauge_flash_access, one clock and a synchronous reset. */
`timescale 1ns/100ps
module flash_access_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command port
    input wire gauge_flash_pkg::cmd_req_t cmd,
    input wire logic [7:0] std_rd_data,
    // Outputs of the block
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic sealed_status_q,
    input wire logic full_access_status_bit_q,
    input wire logic commit_done_q,
    input wire logic commit_fail_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire sum_wr = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_SUM;
    wire key_hi = cmd.wr && cmd.addr == gauge_flash_pkg::CMD_CTRL_HI;
    wire std_rd = cmd.rd && cmd.addr > 8'h01 && cmd.addr < gauge_flash_pkg::CMD_CLASS;
    ////////////////////////////////////////
    property p_rd_ans; cmd.rd |=> rd_valid_q; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_no_rd; !cmd.rd |=> !rd_valid_q; endproperty
    a_no_rd: assert property (p_no_rd) else $error("stray read valid");
    property p_idle0; !rd_valid_q |-> rd_data_q == 8'h00; endproperty
    a_idle0: assert property (p_idle0) else $error("read data not idle");
    property p_std; std_rd |=> rd_data_q == $past(std_rd_data); endproperty
    a_std: assert property (p_std) else $error("standard read lost");
    property p_done; commit_done_q |-> $past(sum_wr); endproperty
    a_done: assert property (p_done) else $error("commit without sum");
    property p_fail; commit_fail_q |-> $past(sum_wr); endproperty
    a_fail: assert property (p_fail) else $error("fail without sum");
    property p_sum; sum_wr && !sealed_status_q |=> commit_done_q ^ commit_fail_q; endproperty
    a_sum: assert property (p_sum) else $error("sum write unanswered");
    property p_unseal; $fell(sealed_status_q) |-> $past(key_hi) || $past(key_hi, 2); endproperty
    a_unseal: assert property (p_unseal) else $error("unsealed without key");
    property p_full;
        $fell(full_access_status_bit_q) |-> $past(key_hi) || $past(key_hi, 2);
    endproperty
    a_full: assert property (p_full) else $error("full access without key");
    property p_order; !full_access_status_bit_q |-> !sealed_status_q; endproperty
    a_order: assert property (p_order) else $error("full access while sealed");
    c_done: cover property (commit_done_q);
    c_fail: cover property (commit_fail_q);
    c_unseal: cover property ($fell(sealed_status_q));
endmodule

// ### sim/host_cmd_model.sv
/* Host model: drives the command port one byte request at a time.
   Assumes every call starts 10 ns after a rising edge of clk. */
`timescale 1ns/100ps
module host_cmd_model (
    // Clock
    input wire logic clk,
    // Command port
    output gauge_flash_pkg::cmd_req_t cmd,
    // Answers
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic commit_done_q,
    input wire logic commit_fail_q
);
    logic got_vld;
    logic got_done;
    logic got_fail;
    logic [7:0] got_rd;
    initial cmd = '0;
    // Unqualified address and data toggle, so nothing can lean on stale values.
    task automatic op(input logic st, input logic w, input logic [7:0] a, input logic [7:0] d);
        cmd = '{st, w, !w, a, d};
        @(posedge clk);
        #10;
        {got_vld, got_rd} = {rd_valid_q, rd_data_q};
        {got_done, got_fail} = {commit_done_q, commit_fail_q};
        cmd = '{1'b0, 1'b0, 1'b0, ~a, ~d};
        @(posedge clk);
        #10;
    endtask
    // A key word goes low byte first, the same as its stored order.
    task automatic key(input logic [7:0] b0, input logic [7:0] b1);
        op(1'b0, 1'b1, gauge_flash_pkg::CMD_CTRL_LO, b0);
        op(1'b0, 1'b1, gauge_flash_pkg::CMD_CTRL_HI, b1);
    endtask
    function automatic logic [7:0] sum_byte(input logic [7:0] w[32]);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 32; i++) begin
            s += w[i];
        end
        return 8'hFF - s;
    endfunction
endmodule

// ### sim/tb_top.sv
/* Testbench top for the block access logic.
   Assumes package, design, checker and host model are compiled first. */
`timescale 1ns/100ps
module tb_top;
    logic clk;
    logic sys_rst;
    logic [7:0] std_rd_data;
    gauge_flash_pkg::cmd_req_t cmd;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    logic sealed_status_q;
    logic full_access_status_bit_q;
    logic commit_done_q;
    logic commit_fail_q;
    logic [7:0] win[32];
    int n_errors;
    int total_checks;
    gauge_flash_access i_dut (.clk, .sys_rst, .cmd, .std_rd_data, .rd_data_q, .rd_valid_q,
        .sealed_status_q, .full_access_status_bit_q, .commit_done_q, .commit_fail_q);
    host_cmd_model i_host (.clk, .cmd, .rd_data_q, .rd_valid_q, .commit_done_q, .commit_fail_q);
    ////////////////////////////////////////
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_byte(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.op(1'b0, 1'b1, a, d);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        i_host.op(1'b0, 1'b0, a, 8'h00);
        chk_bit(nm, 1'b1, i_host.got_vld);
        chk_byte(nm, e, i_host.got_rd);
    endtask
    // A burst past one block wraps its offset, so the extra byte targets window byte zero and the whole burst is discarded.
    task automatic fill(input int n, input logic [7:0] k);
        for (int i = 0; i < n; i++) begin
            win[i % 32] = 8'(i * 7) + k;
            i_host.op(i == 0, 1'b1, 8'h40 + 8'(i % 32), win[i % 32]);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 2000);
        n_errors++;
        summarize();
    end
    initial begin
        n_errors = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        std_rd_data = 8'hA5;
        repeat (5) @(posedge clk);
        #10;
        sys_rst = 1'b0;
        repeat (2) @(posedge clk);
        #10;
        chk_bit("sealed", 1'b1, sealed_status_q);
        wr(8'h3E, 8'h05);
        rd_chk("sealed window", 8'h40, 8'h00);
        rd_chk("std read", 8'h1C, 8'hA5);
        i_host.key(8'h36, 8'h72);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h00);
        i_host.key(8'h04, 8'h14);
        chk_bit("voided keys", 1'b1, sealed_status_q);
        i_host.key(8'h36, 8'h72);
        i_host.key(8'h04, 8'h14);
        chk_bit("unsealed", 1'b0, sealed_status_q);
        $display("test security done");
        wr(8'h61, 8'h00);
        wr(8'h3E, 8'h70);
        wr(8'h3F, 8'h00);
        rd_chk("key byte", 8'h40, 8'h36);
        rd_chk("sum read", 8'h60, 8'h43);
        wr(8'h60, 8'h43);
        chk_bit("key commit", 1'b1, i_host.got_fail);
        wr(8'h3E, 8'h05);
        wr(8'h3F, 8'h01);
        fill(32, 8'h03);
        wr(8'h60, i_host.sum_byte(win) ^ 8'h01);
        chk_bit("bad sum", 1'b1, i_host.got_fail);
        wr(8'h3F, 8'h01);
        rd_chk("kept block", 8'h49, 8'h00);
        fill(32, 8'h03);
        wr(8'h60, i_host.sum_byte(win));
        chk_bit("commit", 1'b1, i_host.got_done);
        i_host.op(1'b1, 1'b1, 8'h45, 8'hC3);
        rd_chk("byte rewrite", 8'h45, 8'hC3);
        rd_chk("byte kept", 8'h46, 8'h2D);
        fill(33, 8'h09);
        rd_chk("discard", 8'h45, 8'h26);
        wr(8'h60, 8'h00);
        chk_bit("discard commit", 1'b1, i_host.got_fail);
        wr(8'h3F, 8'h01);
        rd_chk("stored", 8'h5F, 8'hDC);
        $display("test block done");
        i_host.key(8'hFF, 8'hFF);
        i_host.key(8'hFF, 8'hFF);
        chk_bit("full access", 1'b0, full_access_status_bit_q);
        i_host.op(1'b1, 1'b1, 8'h3E, 8'h70);
        wr(8'h3F, 8'h00);
        wr(8'h60, 8'h43);
        chk_bit("key commit", 1'b1, i_host.got_done);
        wr(8'h61, 8'h01);
        wr(8'h3F, 8'h01);
        fill(32, 8'h01);
        wr(8'h60, i_host.sum_byte(win));
        chk_bit("block A commit", 1'b1, i_host.got_done);
        wr(8'h00, 8'h20);
        wr(8'h01, 8'h00);
        chk_bit("resealed", 1'b1, sealed_status_q);
        chk_bit("full cleared", 1'b1, full_access_status_bit_q);
        wr(8'h3F, 8'h01);
        rd_chk("block A", 8'h42, 8'h0F);
        wr(8'h3F, 8'h00);
        rd_chk("index refused", 8'h40, 8'h01);
        $display("test access levels done");
        summarize();
    end
endmodule
bind gauge_flash_access flash_access_chk i_chk (.clk, .sys_rst, .cmd, .std_rd_data, .rd_data_q,
    .rd_valid_q, .sealed_status_q, .full_access_status_bit_q, .commit_done_q, .commit_fail_q);
